// *** src/dmadst_pkg.sv ***
// package for the dma destination address register bank
// assumes apb access with 32-bit data, one register per word
`default_nettype none
package dmadst_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [31:0] DMADST_IDX_LOW_CH0 = 32'hFFFFF084;
  localparam logic [31:0] DMADST_IDX_HIGH_CH0 = 32'hFFFFF086;
  localparam logic [31:0] DMADST_IDX_LOW_CH1 = 32'hFFFFF08C;
  localparam logic [31:0] DMADST_IDX_HIGH_CH1 = 32'hFFFFF08E;
  localparam logic [31:0] DMADST_IDX_LOW_CH2 = 32'hFFFFF094;
  localparam logic [31:0] DMADST_IDX_HIGH_CH2 = 32'hFFFFF096;
  localparam logic [31:0] DMADST_IDX_LOW_CH3 = 32'hFFFFF09C;
  localparam logic [31:0] DMADST_IDX_HIGH_CH3 = 32'hFFFFF09E;
  // index step between channels, low to high step
  localparam logic [31:0] DMADST_IDX_CH_STEP = 32'h00000008;
  localparam logic [31:0] DMADST_IDX_HI_STEP = 32'h00000002;

  // ****************************************
  // field layout
  // ****************************************
  localparam int DMADST_NUM_CH = 4;
  localparam int DMADST_REG_W = 16;
  localparam int DMADST_ADDR_W = 28;
  localparam int DMADST_RAM_SEL_BIT = 15;
  localparam int DMADST_UPPER_W = 12;
  localparam logic [15:0] DMADST_RST_VAL = 16'h0000;
  localparam logic [1:0] DMADST_FULL_STRB = 2'h3;

  // destination of one channel
  typedef struct packed {
    logic internal_ram_select;
    logic [DMADST_ADDR_W-1:0] dest_address_field;
  } dmadst_dest_t;

endpackage
`default_nettype wire

// *** src/dmadst_regs.sv ***
// four-channel dma destination address registers, double buffered
// assumes an apb master on sys_clk and a transfer engine on the same clock
// assumes reload pulses and active flags come from that engine
// Summary of operation
// - four channels, 28-bit destination address each
// - high and low 16-bit register halves
// - buffer stage writable while transfer runs
// - flyby transfer ignores destination address
// - registers accessed as whole 16-bit units
`timescale 1ns/100ps
`default_nettype none
module dmadst_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dmadst_pkg::DMADST_NUM_CH-1:0] transfer_type_select,
  input wire logic [dmadst_pkg::DMADST_NUM_CH-1:0] xfer_active,
  input wire logic [dmadst_pkg::DMADST_NUM_CH-1:0] next_reload,
  output dmadst_pkg::dmadst_dest_t [dmadst_pkg::DMADST_NUM_CH-1:0] cur_dest,
  output logic [dmadst_pkg::DMADST_NUM_CH-1:0] dest_used
);
  import dmadst_pkg::*;

  // word index width: paddr carries byte addresses of 32-bit words
  localparam int IW = ADDR_W - 2;

  // ****************************************
  // apb decode
  // ****************************************
  logic [IW-1:0] idx;
  logic access;
  logic first_access;
  logic wr_ok;
  logic [DMADST_NUM_CH-1:0] hit_lo;
  logic [DMADST_NUM_CH-1:0] hit_hi;
  logic hit;
  logic [15:0] rd_mux;
  logic err_nxt;
  logic [31:0] rdata_nxt;
  dmadst_dest_t [DMADST_NUM_CH-1:0] buf_r;

  // word index from the byte address
  assign idx = paddr[ADDR_W-1:2];
  // first access cycle: the answer is prepared here
  assign first_access = psel && penable && !pready;
  // second access cycle: the transfer completes at its closing edge
  assign access = psel && penable && pready;
  // only full 16-bit writes are accepted
  assign wr_ok = (pstrb[1:0] == DMADST_FULL_STRB);

  // ****************************************
  // per-channel storage
  // ****************************************
  // the working stage feeds the transfer engine and the buffer stage is
  // what software sees, so a running transfer never picks up a
  // half-written address while its successor is being loaded
  genvar g;
  generate
    for (g = 0; g < DMADST_NUM_CH; g++)
    begin : ch
      localparam logic [31:0] LO_IDX =
        DMADST_IDX_LOW_CH0 + DMADST_IDX_CH_STEP * g;
      localparam logic [31:0] HI_IDX = LO_IDX + DMADST_IDX_HI_STEP;
      logic wr_lo;
      logic wr_hi;
      dmadst_dest_t nxt;

      // each register sits at the word index of its offset; only the
      // low index bits that paddr carries are compared
      assign hit_lo[g] = (idx == LO_IDX[IW-1:0]);
      assign hit_hi[g] = (idx == HI_IDX[IW-1:0]);
      assign wr_lo = access && pwrite && wr_ok && hit_lo[g];
      assign wr_hi = access && pwrite && wr_ok && hit_hi[g];

      // buffer value after this cycle's write
      always_comb
      begin
        nxt = buf_r[g];
        if (wr_lo)
        begin
          nxt.dest_address_field[15:0] = pwdata[15:0];
        end
        if (wr_hi)
        begin
          nxt.internal_ram_select = pwdata[DMADST_RAM_SEL_BIT];
          nxt.dest_address_field[27:16] =
            pwdata[DMADST_UPPER_W-1:0];
        end
      end

      // software-side buffer stage
      always_ff @(posedge sys_clk)
      begin
        if (reset)
        begin
          buf_r[g] <= '0;
        end
        else if (clk_en)
        begin
          buf_r[g] <= nxt;
        end
      end

      // working stage: follows writes when idle, reloads on request
      always_ff @(posedge sys_clk)
      begin
        if (reset)
        begin
          cur_dest[g] <= '0;
        end
        else if (clk_en)
        begin
          // a write in the reload cycle goes straight through
          if (next_reload[g] || !xfer_active[g])
          begin
            cur_dest[g] <= nxt;
          end
        end
      end

      // address unused during flyby transfers
      // low means the engine must not use cur_dest
      always_ff @(posedge sys_clk)
      begin
        if (reset)
        begin
          dest_used[g] <= 1'b0;
        end
        else if (clk_en)
        begin
          dest_used[g] <= !transfer_type_select[g];
        end
      end
    end
  endgenerate

  // any register of the bank addressed
  assign hit = |{hit_lo, hit_hi};

  // ****************************************
  // read path
  // ****************************************
  // read multiplexer over the buffer stage
  // reads see what software last wrote, not the running address
  always_comb
  begin
    rd_mux = DMADST_RST_VAL;
    for (int i = 0; i < DMADST_NUM_CH; i++)
    begin
      if (hit_lo[i])
      begin
        rd_mux = buf_r[i].dest_address_field[15:0];
      end
      if (hit_hi[i])
      begin
        rd_mux = {buf_r[i].internal_ram_select, 3'h0,
                  buf_r[i].dest_address_field[27:16]};
      end
    end
  end

  // ****************************************
  // apb answer: one wait state
  // ****************************************
  // refusal: unmapped index, or a write narrower than 16 bits
  assign err_nxt = !hit || (pwrite && !wr_ok);
  // writes and refused reads return zero
  assign rdata_nxt = (pwrite || !hit) ? 32'h00000000 : {16'h0000, rd_mux};

  // ready: a one-cycle pulse in the second access cycle
  // clk_en low stalls the answer along with all state
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= first_access;
    end
  end

  // error stands only beside ready
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pslverr <= first_access && err_nxt;
    end
  end

  // read data holds until the next access is answered
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      prdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      if (first_access)
      begin
        prdata <= rdata_nxt;
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/dmadst_regs_assertions.sv ***
// checker for the dma destination address registers
// assumes clk_en high during bus transfers and ADDR_W at its default
`timescale 1ns/100ps
`default_nettype none
module dmadst_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] transfer_type_select,
  input wire logic [3:0] xfer_active,
  input wire logic [3:0] next_reload,
  input wire dmadst_pkg::dmadst_dest_t [3:0] cur_dest,
  input wire logic [3:0] dest_used
);
  import dmadst_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // completed write
  sequence s_wdone;
    psel && penable && pready && pwrite;
  endsequence
  // answered write with a strobe narrower than 16 bits
  sequence s_wpart;
    pready && pwrite && pstrb[1:0] != 2'h3;
  endsequence
  // answered read of an upper half
  sequence s_rdhi;
    pready && !pwrite && paddr[3];
  endsequence
  AST_RDY: assert property ($rose(penable) && psel |=> pready)
    else $error("ready missing after access");
  AST_ERR: assert property (s_wpart |-> pslverr)
    else $error("partial write not refused");
  AST_HI: assert property (s_rdhi |-> prdata[31:16] == 16'h0000
    && prdata[14:12] == 3'h0)
    else $error("upper read bits not zero");
  AST_FLY: assert property (!$past(reset) && $past(clk_en)
    |-> dest_used == ~$past(transfer_type_select))
    else $error("dest used wrong");
  AST_HOLD: assert property (!$past(reset)
    && $past(xfer_active[0] && !next_reload[0]) |-> $stable(cur_dest[0]))
    else $error("working address moved");
  AST_TRK: assert property (s_wdone ##0 (paddr == 12'h210
    && !pslverr && !xfer_active[0])
    |=> cur_dest[0][15:0] == $past(pwdata[15:0]))
    else $error("low half not loaded");
endmodule
bind dmadst_regs dmadst_chk u_chk (.sys_clk(sys_clk), .reset(reset),
  .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .transfer_type_select(transfer_type_select),
  .xfer_active(xfer_active), .next_reload(next_reload),
  .cur_dest(cur_dest), .dest_used(dest_used));
`default_nettype wire

// *** tb/test_dmadst_regs.sv ***
// bench for dmadst_regs over apb
// assumes the checker is bound onto the design
`timescale 1ns/100ps
`default_nettype none
module test_dmadst_regs;
  import dmadst_pkg::*;
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0] pstrb = 4'h0, tts = 4'h0, act = 4'h0, rld = 4'h0, dest_used;
  logic pready, pslverr, rerr;
  logic clk_en = 1'b1;
  dmadst_dest_t [3:0] cur_dest;
  int num_errors = 0, comparisons = 0;
  dmadst_regs i_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transfer_type_select(tts), .xfer_active(act),
    .next_reload(rld), .cur_dest(cur_dest), .dest_used(dest_used));
  // 200 MHz clock
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one apb transfer, answer left in rdat and rerr
  task automatic bus(logic w, logic [11:0] a, logic [15:0] d, logic [3:0] s);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      $display("unexpected pready exp 1 got %b", pready);
      stop_test();
    end
  endtask
  initial
  begin
    tk(3);
    reset <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      bus(0, 12'h210 + 12'(c * 32), 16'h0, 4'h0);
      chk("reset low", 32'h0, rdat);
      bus(1, 12'h218 + 12'(c * 32), 16'hFFFF, 4'hF);
      chk("high write err", 32'h0, 32'(rerr));
      bus(1, 12'h210 + 12'(c * 32), 16'hA5A0 + 16'(c), 4'hF);
      bus(0, 12'h218 + 12'(c * 32), 16'h0, 4'h0);
      chk("high", 32'h8FFF, rdat);
      chk("dest", 32'h1FFFA5A0 + 32'(c), 32'(cur_dest[c]));
    end
    $display("test channels done");
    act <= 4'h1;
    bus(1, 12'h210, 16'h5555, 4'h3);
    bus(0, 12'h210, 16'h0, 4'h0);
    chk("buffer", 32'h5555, rdat);
    chk("held", 32'h1FFFA5A0, 32'(cur_dest[0]));
    rld <= 4'h1;
    tk(1);
    rld <= 4'h0;
    tk(1);
    chk("reload", 32'h1FFF5555, 32'(cur_dest[0]));
    act <= 4'h0;
    $display("test buffer done");
    tts <= 4'hA;
    tk(2);
    chk("used", 32'h5, 32'(dest_used));
    clk_en <= 1'b0;
    tts <= 4'h0;
    tk(2);
    chk("frozen", 32'h5, 32'(dest_used));
    clk_en <= 1'b1;
    tk(2);
    chk("used again", 32'hF, 32'(dest_used));
    $display("test flyby done");
    bus(1, 12'h210, 16'h0, 4'h1);
    chk("partial err", 32'h1, 32'(rerr));
    bus(0, 12'h210, 16'h0, 4'h0);
    chk("kept", 32'h5555, rdat);
    bus(0, 12'h200, 16'h0, 4'h0);
    chk("unmapped err", 32'h1, 32'(rerr));
    $display("test refusals done");
    stop_test();
  end
endmodule
`default_nettype wire
